// ===== ccs_consts.vh
// Constants of the clock source and start-up sequencer: register offsets, field positions,
// reset values and cycle counts.
// Assumes inclusion by bare name from the design files of this block.
//
// Functional notes
// - The four-bit clock source select fuse field picks crystal (1111-1010), low-frequency crystal (1001), external RC (1000-0101), internal RC (0100-0001) or external clock (0000).
// - Every fuse bit read as one is unprogrammed and read as zero is programmed.
// - Waking from power-down or power-save counts the configured number of selected-source clock cycles before execution resumes.
// - Start from reset inserts an extra delay timed by the watchdog oscillator, not the main clock, unless the start-up code selects no reset delay.
// - The reset delay is either 4,096 or 65,536 watchdog oscillator cycles long.
// - The shipped configuration is clock field 0001 with start-up field 10, the 1 MHz internal RC with slowly rising power.
// - In crystal mode the upper three select bits choose range 101, 110 or 111, and a programmed amplifier option gives all three the wide range.
// - Crystal with select bit 0 at zero: start-up codes 00/01 wake in 258 cycles, 10/11 in 1K, with reset delays 4K, 64K, none, 4K.
// - Crystal with select bit 0 at one: code 00 wakes in 1K with 64K delay, codes 01/10/11 wake in 16K with none, 4K, 64K delay.
// - The asynchronous timer clock runs only while the main clock comes from the internal oscillator, which must be over four times the timer frequency.
// - Clocks of unused domains are stopped according to the active sleep mode.
// - The program store clock is enabled and gated together with the core clock.
// - The converter clock keeps running while core and peripheral clocks are stopped for a conversion.
// - Internal RC wakes in 6 cycles; start-up codes 00/01/10 give no, 4K, 64K reset delay and 11 is reserved.
// - Low-frequency crystal codes 00/01 wake in 1K with 4K/64K delay, code 10 wakes in 32K with 64K delay, 11 is reserved.
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CCS_ADDR_CONTROL      12'h000
`define CCS_ADDR_STATUS       12'h004

`define CCS_CTL_SLEEP_GO      0
`define CCS_CTL_MODE_LSB      1
`define CCS_CTL_MODE_MSB      3
`define CCS_CTL_ASYNC_REQ     4
`define CCS_CTL_CONV_EN       5

`define CCS_STS_STATE_LSB     0
`define CCS_STS_CLASS_LSB     4
`define CCS_STS_RESERVED      8
`define CCS_STS_ASYNC_REFUSED 9
`define CCS_STS_CLOCK_SOURCE_SELECT_LSB     16
`define CCS_STS_SUT_LSB       20
`define CCS_STS_AMPLIFIER_OPTION         22

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCS_MODE_RST          3'h0
`define CCS_ASYNC_REQ_RST     1'h0
`define CCS_CONV_EN_RST       1'h0
`define CCS_FUSE_CLOCK_SOURCE_SELECT_RST    4'h1
`define CCS_FUSE_SUT_RST      2'h2
`define CCS_FUSE_AMPLIFIER_OPTION_RST    1'h1

// ----------------------------------------------------------------------------
// Cycle counts of the oscillators
// ----------------------------------------------------------------------------
`define CCS_WAKE_6            17'h00006
`define CCS_WAKE_18           17'h00012
`define CCS_WAKE_258          17'h00102
`define CCS_WAKE_1K           17'h00400
`define CCS_WAKE_16K          17'h04000
`define CCS_WAKE_32K          17'h08000
`define CCS_WDT_4K            17'h01000
`define CCS_WDT_64K           17'h10000
`define CCS_FUSE_SETTLE       2'h3

`endif

// ===== ccs_cycle_counter.v
// Counter of rising edges of a free-running oscillator that arrives from outside the clock domain.
// Assumes the system clock is more than twice the oscillator frequency.
`timescale 1ns/100ps

module ccs_cycle_counter (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Oscillator input, asynchronous
   input  wire        osc_in,
   // Control from the same clock domain
   input  wire        start,
   input  wire [16:0] load,
   // Result
   output reg         done
);

   reg        sync1_reg;
   reg        sync2_reg;
   reg        sync3_reg;
   reg        busy_reg;
   reg [16:0] remain_reg;
   wire       osc_rise;

   assign osc_rise = sync2_reg & ~sync3_reg;

   // ----------------------------------------------------------------------------
   // Synchroniser and countdown
   // ----------------------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         sync1_reg  <= 1'b0;
         sync2_reg  <= 1'b0;
         sync3_reg  <= 1'b0;
         busy_reg   <= 1'b0;
         remain_reg <= 17'h00000;
         done       <= 1'b0;
      end else begin
         sync1_reg <= osc_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         done      <= 1'b0;
         if (start) begin
            busy_reg   <= 1'b1;
            remain_reg <= load;
         end else if (busy_reg && osc_rise) begin
            remain_reg <= remain_reg - 17'h00001;
            if (remain_reg == 17'h00001) begin
               busy_reg <= 1'b0;
               done     <= 1'b1;
            end
         end
      end
   end

endmodule // ccs_cycle_counter

// ===== ccs_startup_sequencer.v
// Clock source decode, start-up sequencing and domain clock gating, with an APB register slave.
// Assumes fuse, wake and oscillator inputs come from pins outside the CLOCK domain,
// and that the domain clock enables drive glitch-free gates elsewhere.
`timescale 1ns/100ps
`include "ccs_consts.vh"

module ccs_startup_sequencer #(
   parameter [16:0] WDT_LONG    = `CCS_WDT_64K,
   parameter [16:0] WAKE_16K    = `CCS_WAKE_16K,
   parameter [16:0] WAKE_32K    = `CCS_WAKE_32K
) (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        NRST,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // Fuses and oscillators
   input  wire [3:0]  CLOCK_SOURCE_SELECT,
   input  wire [1:0]  STARTUP_TIME_SELECT,
   input  wire        AMPLIFIER_OPTION,
   input  wire        MAIN_OSC_IN,
   input  wire        WATCHDOG_OSC_IN,
   input  wire        WAKE,
   // Domain clock enables and oscillator control
   output reg         CORE_CLOCK_EN,
   output reg         PERIPHERAL_CLOCK_EN,
   output reg         PROGRAM_STORE_CLOCK_EN,
   output reg         ASYNC_TIMER_CLOCK_EN,
   output reg         CONVERTER_CLOCK_EN,
   output reg         MAIN_OSC_EN,
   output reg  [1:0]  OSC_RANGE,
   output reg         AMP_FULL_SWING,
   output reg         EXECUTE_RELEASE
);

   // ----------------------------------------------------------------------------
   // Encodings and declarations
   // ----------------------------------------------------------------------------
   localparam [2:0] ST_FUSE  = 3'h0;
   localparam [2:0] ST_RDLY  = 3'h1;
   localparam [2:0] ST_START = 3'h2;
   localparam [2:0] ST_RUN   = 3'h3;
   localparam [2:0] ST_SLEEP = 3'h4;
   localparam [2:0] CL_CRYSTAL = 3'h0;
   localparam [2:0] CL_LOWFREQ = 3'h1;
   localparam [2:0] CL_EXT_RC  = 3'h2;
   localparam [2:0] CL_INT_RC  = 3'h3;
   localparam [2:0] CL_EXT_CLK = 3'h4;
   localparam [2:0] SM_IDLE       = 3'h0;
   localparam [2:0] SM_CONVERT    = 3'h1;
   localparam [2:0] SM_POWER_DOWN = 3'h2;
   localparam [2:0] SM_POWER_SAVE = 3'h3;
   localparam [1:0] RD_NONE  = 2'h0;
   localparam [1:0] RD_SHORT = 2'h1;
   localparam [1:0] RD_LONG  = 2'h2;
   localparam [1:0] RANGE_WIDE = 2'h3;

   reg  [2:0]  state_reg, state_next, mode_reg, src_class;
   reg  [3:0]  clock_source_select_reg, fuse_sel_s1_reg, fuse_sel_s2_reg;
   reg  [1:0]  settle_reg, sut_reg, fuse_sut_s1_reg, fuse_sut_s2_reg, range_next;
   reg         fuse_amp_s1_reg, fuse_amp_s2_reg, wake_s1_reg, wake_s2_reg, amplifier_option_reg, async_req_reg, conv_en_reg;
   reg         wdt_start, osc_start, core_next, periph_next, async_next, conv_next, osc_next;
   reg  [19:0] timing;
   reg  [31:0] rdata_next;
   wire [16:0] wake_count;
   wire [1:0]  rdly_sel;
   wire        wdt_done, osc_done, fuse_reserved, amp_programmed, async_refused;
   wire        apb_access, apb_done, sel_control, sel_status, sleep_go;

   // ----------------------------------------------------------------------------
   // Start-up table: {reserved, reset delay select, wake count}
   // ----------------------------------------------------------------------------
   function [19:0] startup_of;
      input [3:0] sel;
      input [1:0] startup_time_select;
      begin
         if (sel >= 4'ha) begin
            case ({sel[0], startup_time_select})
               3'h0:    startup_of = {1'b0, RD_SHORT, `CCS_WAKE_258};
               3'h1:    startup_of = {1'b0, RD_LONG,  `CCS_WAKE_258};
               3'h2:    startup_of = {1'b0, RD_NONE,  `CCS_WAKE_1K};
               3'h3:    startup_of = {1'b0, RD_SHORT, `CCS_WAKE_1K};
               3'h4:    startup_of = {1'b0, RD_LONG,  `CCS_WAKE_1K};
               3'h5:    startup_of = {1'b0, RD_NONE,  WAKE_16K};
               3'h6:    startup_of = {1'b0, RD_SHORT, WAKE_16K};
               default: startup_of = {1'b0, RD_LONG,  WAKE_16K};
            endcase
         end else if (sel == 4'h9) begin
            case (startup_time_select)
               2'h0:    startup_of = {1'b0, RD_SHORT, `CCS_WAKE_1K};
               2'h1:    startup_of = {1'b0, RD_LONG,  `CCS_WAKE_1K};
               2'h2:    startup_of = {1'b0, RD_LONG,  WAKE_32K};
               default: startup_of = {1'b1, RD_LONG,  WAKE_32K};
            endcase
         end else if (sel >= 4'h5) begin
            case (startup_time_select)
               2'h0:    startup_of = {1'b0, RD_NONE,  `CCS_WAKE_18};
               2'h1:    startup_of = {1'b0, RD_SHORT, `CCS_WAKE_18};
               2'h2:    startup_of = {1'b0, RD_LONG,  `CCS_WAKE_18};
               default: startup_of = {1'b0, RD_SHORT, `CCS_WAKE_6};
            endcase
         end else begin
            case (startup_time_select)
               2'h0:    startup_of = {1'b0, RD_NONE,  `CCS_WAKE_6};
               2'h1:    startup_of = {1'b0, RD_SHORT, `CCS_WAKE_6};
               2'h2:    startup_of = {1'b0, RD_LONG,  `CCS_WAKE_6};
               default: startup_of = {1'b1, RD_LONG,  `CCS_WAKE_6};
            endcase
         end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Fuse decode
   // ----------------------------------------------------------------------------
   // A fuse read as zero is programmed.
   assign amp_programmed = ~amplifier_option_reg;

   always @* begin
      if (clock_source_select_reg >= 4'ha) src_class = CL_CRYSTAL;
      else if (clock_source_select_reg == 4'h9) src_class = CL_LOWFREQ;
      else if (clock_source_select_reg >= 4'h5) src_class = CL_EXT_RC;
      else if (clock_source_select_reg >= 4'h1) src_class = CL_INT_RC;
      else src_class = CL_EXT_CLK;
      timing = startup_of(clock_source_select_reg, sut_reg);
      // Crystal codes 101, 110 and 111 map to ranges 0, 1 and 2.
      if (src_class != CL_CRYSTAL) range_next = 2'h0;
      else if (amp_programmed) range_next = RANGE_WIDE;
      else range_next = clock_source_select_reg[2:1] - 2'h1;
   end

   assign wake_count    = timing[16:0];
   assign rdly_sel      = timing[18:17];
   assign fuse_reserved = timing[19];
   assign async_refused = async_req_reg & (src_class != CL_INT_RC);

   // ----------------------------------------------------------------------------
   // Oscillator counters
   // ----------------------------------------------------------------------------
   ccs_cycle_counter u_wdt_count (
      .clk    (CLOCK),
      .rst_n  (NRST),
      .osc_in (WATCHDOG_OSC_IN),
      .start  (wdt_start),
      .load   ((rdly_sel == RD_LONG) ? WDT_LONG : `CCS_WDT_4K),
      .done   (wdt_done)
   );

   ccs_cycle_counter u_osc_count (
      .clk    (CLOCK),
      .rst_n  (NRST),
      .osc_in (MAIN_OSC_IN),
      .start  (osc_start),
      .load   (wake_count),
      .done   (osc_done)
   );

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   assign apb_access  = PSEL & PENABLE;
   assign apb_done    = apb_access & PREADY;
   assign sel_control = (PADDR == `CCS_ADDR_CONTROL);
   assign sel_status  = (PADDR == `CCS_ADDR_STATUS);
   assign sleep_go    = apb_done & PWRITE & sel_control & PWDATA[`CCS_CTL_SLEEP_GO];

   always @* begin
      rdata_next = 32'h00000000;
      if (sel_control) begin
         rdata_next[`CCS_CTL_MODE_MSB:`CCS_CTL_MODE_LSB] = mode_reg;
         rdata_next[`CCS_CTL_ASYNC_REQ]                   = async_req_reg;
         rdata_next[`CCS_CTL_CONV_EN]                     = conv_en_reg;
      end else if (sel_status) begin
         rdata_next[`CCS_STS_STATE_LSB+2:`CCS_STS_STATE_LSB] = state_reg;
         rdata_next[`CCS_STS_CLASS_LSB+2:`CCS_STS_CLASS_LSB] = src_class;
         rdata_next[`CCS_STS_RESERVED]                       = fuse_reserved;
         rdata_next[`CCS_STS_ASYNC_REFUSED]                  = async_refused;
         rdata_next[`CCS_STS_CLOCK_SOURCE_SELECT_LSB+3:`CCS_STS_CLOCK_SOURCE_SELECT_LSB] = clock_source_select_reg;
         rdata_next[`CCS_STS_SUT_LSB+1:`CCS_STS_SUT_LSB]     = sut_reg;
         rdata_next[`CCS_STS_AMPLIFIER_OPTION]                          = amplifier_option_reg;
      end
   end

   // ----------------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      wdt_start  = 1'b0;
      osc_start  = 1'b0;
      case (state_reg)
         ST_FUSE: begin
            if (settle_reg == `CCS_FUSE_SETTLE) begin
               if (rdly_sel != RD_NONE) begin
                  state_next = ST_RDLY;
                  wdt_start  = 1'b1;
               end else begin
                  state_next = ST_START;
                  osc_start  = 1'b1;
               end
            end
         end
         ST_RDLY: begin
            if (wdt_done) begin
               state_next = ST_START;
               osc_start  = 1'b1;
            end
         end
         ST_START: if (osc_done) state_next = ST_RUN;
         ST_RUN: if (sleep_go) state_next = ST_SLEEP;
         ST_SLEEP: begin
            if (wake_s2_reg) begin
               if (mode_reg == SM_POWER_DOWN || mode_reg == SM_POWER_SAVE) begin
                  state_next = ST_START;
                  osc_start  = 1'b1;
               end else state_next = ST_RUN;
            end
         end
         default: state_next = ST_FUSE;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Domain gating
   // ----------------------------------------------------------------------------
   always @* begin
      core_next   = 1'b0;
      periph_next = 1'b0;
      async_next  = 1'b0;
      conv_next   = 1'b0;
      osc_next    = 1'b1;
      if (state_next == ST_RUN) begin
         core_next   = 1'b1;
         periph_next = 1'b1;
         async_next  = 1'b1;
         conv_next   = conv_en_reg;
      end else if (state_next == ST_SLEEP) begin
         case (mode_reg)
            SM_IDLE: begin
               periph_next = 1'b1;
               async_next  = 1'b1;
               conv_next   = conv_en_reg;
            end
            SM_CONVERT: begin
               async_next = 1'b1;
               conv_next  = 1'b1;
            end
            SM_POWER_SAVE: begin
               async_next = 1'b1;
               osc_next   = 1'b0;
            end
            default: osc_next = 1'b0;
         endcase
      end
      async_next = async_next & async_req_reg & (src_class == CL_INT_RC);
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK) begin
      if (!NRST) begin
         state_reg              <= ST_FUSE;
         settle_reg             <= 2'h0;
         fuse_sel_s1_reg        <= `CCS_FUSE_CLOCK_SOURCE_SELECT_RST;
         fuse_sel_s2_reg        <= `CCS_FUSE_CLOCK_SOURCE_SELECT_RST;
         fuse_sut_s1_reg        <= `CCS_FUSE_SUT_RST;
         fuse_sut_s2_reg        <= `CCS_FUSE_SUT_RST;
         fuse_amp_s1_reg        <= `CCS_FUSE_AMPLIFIER_OPTION_RST;
         fuse_amp_s2_reg        <= `CCS_FUSE_AMPLIFIER_OPTION_RST;
         wake_s1_reg            <= 1'b0;
         wake_s2_reg            <= 1'b0;
         clock_source_select_reg              <= `CCS_FUSE_CLOCK_SOURCE_SELECT_RST;
         sut_reg                <= `CCS_FUSE_SUT_RST;
         amplifier_option_reg              <= `CCS_FUSE_AMPLIFIER_OPTION_RST;
         mode_reg               <= `CCS_MODE_RST;
         async_req_reg          <= `CCS_ASYNC_REQ_RST;
         conv_en_reg            <= `CCS_CONV_EN_RST;
         PRDATA                 <= 32'h00000000;
         PREADY                 <= 1'b0;
         PSLVERR                <= 1'b0;
         CORE_CLOCK_EN          <= 1'b0;
         PERIPHERAL_CLOCK_EN    <= 1'b0;
         PROGRAM_STORE_CLOCK_EN <= 1'b0;
         ASYNC_TIMER_CLOCK_EN   <= 1'b0;
         CONVERTER_CLOCK_EN     <= 1'b0;
         MAIN_OSC_EN            <= 1'b1;
         OSC_RANGE              <= 2'h0;
         AMP_FULL_SWING         <= 1'b0;
         EXECUTE_RELEASE        <= 1'b0;
      end else begin
         state_reg       <= state_next;
         fuse_sel_s1_reg <= CLOCK_SOURCE_SELECT;
         fuse_sel_s2_reg <= fuse_sel_s1_reg;
         fuse_sut_s1_reg <= STARTUP_TIME_SELECT;
         fuse_sut_s2_reg <= fuse_sut_s1_reg;
         fuse_amp_s1_reg <= AMPLIFIER_OPTION;
         fuse_amp_s2_reg <= fuse_amp_s1_reg;
         wake_s1_reg     <= WAKE;
         wake_s2_reg     <= wake_s1_reg;
         // Fuses are sampled once, after the synchronisers have filled.
         if (state_reg == ST_FUSE && settle_reg != `CCS_FUSE_SETTLE) begin
            settle_reg <= settle_reg + 2'h1;
            if (settle_reg == `CCS_FUSE_SETTLE - 2'h1) begin
               clock_source_select_reg <= fuse_sel_s2_reg;
               sut_reg   <= fuse_sut_s2_reg;
               amplifier_option_reg <= fuse_amp_s2_reg;
            end
         end
         PREADY  <= apb_access & ~PREADY;
         PSLVERR <= apb_access & ~PREADY & ~(sel_control | sel_status);
         if (apb_access && !PREADY) begin
            PRDATA <= rdata_next;
         end
         if (apb_done && PWRITE && sel_control) begin
            mode_reg      <= PWDATA[`CCS_CTL_MODE_MSB:`CCS_CTL_MODE_LSB];
            async_req_reg <= PWDATA[`CCS_CTL_ASYNC_REQ];
            conv_en_reg   <= PWDATA[`CCS_CTL_CONV_EN];
         end
         CORE_CLOCK_EN          <= core_next;
         PROGRAM_STORE_CLOCK_EN <= core_next;
         PERIPHERAL_CLOCK_EN    <= periph_next;
         ASYNC_TIMER_CLOCK_EN   <= async_next;
         CONVERTER_CLOCK_EN     <= conv_next;
         MAIN_OSC_EN            <= osc_next;
         OSC_RANGE              <= range_next;
         AMP_FULL_SWING         <= (src_class == CL_CRYSTAL) & amp_programmed;
         EXECUTE_RELEASE        <= (state_next == ST_RUN);
      end
   end

endmodule // ccs_startup_sequencer

// ===== ccs_seq_properties.sv
// Port checker for the clock source and start-up sequencer.
// Assumes it is bound to ccs_startup_sequencer and sees only that module's ports.
`timescale 1ns/100ps

module ccs_seq_properties (
   // Clock, reset and bus handshake
   input wire logic       CLOCK, NRST, PSEL, PENABLE, PREADY, PSLVERR,
   // Domain enables and oscillator control
   input wire logic       CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, PROGRAM_STORE_CLOCK_EN,
   input wire logic       ASYNC_TIMER_CLOCK_EN, MAIN_OSC_EN, AMP_FULL_SWING, EXECUTE_RELEASE,
   input wire logic [1:0] OSC_RANGE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   // ----------------------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------------------
   sequence s_access_start; PSEL && !PENABLE ##1 PSEL && PENABLE; endsequence
   sequence s_answer; !PREADY ##1 PREADY; endsequence
   property p_apb_wait; s_access_start |-> s_answer; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("ready not in second access cycle");
   property p_ready_pulse; PREADY |=> !PREADY; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held two cycles");
   property p_err_ready; PSLVERR |-> PREADY; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   // ----------------------------------------------------------------------------
   // Clock gating and start-up
   // ----------------------------------------------------------------------------
   property p_flash_core; PROGRAM_STORE_CLOCK_EN == CORE_CLOCK_EN; endproperty
   a_flash_core: assert property (p_flash_core) else $error("store clock apart from core");
   property p_release_gates; $rose(EXECUTE_RELEASE) |-> CORE_CLOCK_EN && PERIPHERAL_CLOCK_EN; endproperty
   a_release_gates: assert property (p_release_gates) else $error("gates closed at release");
   property p_core_run; CORE_CLOCK_EN |-> EXECUTE_RELEASE; endproperty
   a_core_run: assert property (p_core_run) else $error("core clock before release");
   property p_hold_after_reset; $rose(NRST) |-> !EXECUTE_RELEASE [*8]; endproperty
   a_hold_after_reset: assert property (p_hold_after_reset) else $error("release too soon");
   property p_osc_off; !MAIN_OSC_EN |-> !CORE_CLOCK_EN && !PERIPHERAL_CLOCK_EN; endproperty
   a_osc_off: assert property (p_osc_off) else $error("clocks on with oscillator off");
   property p_async_intrc; ASYNC_TIMER_CLOCK_EN |-> OSC_RANGE == 2'h0 && !AMP_FULL_SWING; endproperty
   a_async_intrc: assert property (p_async_intrc) else $error("async clock on crystal");
   property p_wide; AMP_FULL_SWING |-> OSC_RANGE == 2'h3; endproperty
   a_wide: assert property (p_wide) else $error("full swing without wide range");
endmodule // ccs_seq_properties

bind ccs_startup_sequencer ccs_seq_properties i_props (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_CLOCK_EN(CORE_CLOCK_EN),
   .PERIPHERAL_CLOCK_EN(PERIPHERAL_CLOCK_EN), .PROGRAM_STORE_CLOCK_EN(PROGRAM_STORE_CLOCK_EN),
   .ASYNC_TIMER_CLOCK_EN(ASYNC_TIMER_CLOCK_EN), .MAIN_OSC_EN(MAIN_OSC_EN),
   .AMP_FULL_SWING(AMP_FULL_SWING), .EXECUTE_RELEASE(EXECUTE_RELEASE), .OSC_RANGE(OSC_RANGE));

// ===== tb_top.sv
// Self-checking bench of the clock source and start-up sequencer.
// Assumes free-running oscillators and shortened long counts through parameters.
`timescale 1ns/100ps

module tb_top;
   logic        CLOCK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, AMPLIFIER_OPTION = 1;
   logic        MAIN_OSC_IN = 0, WATCHDOG_OSC_IN = 0, WAKE = 0;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, rd;
   logic [3:0]  CLOCK_SOURCE_SELECT = 4'h1;
   logic [1:0]  STARTUP_TIME_SELECT = 2'h2, OSC_RANGE;
   logic        PREADY, PSLVERR, CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, PROGRAM_STORE_CLOCK_EN, er;
   logic        ASYNC_TIMER_CLOCK_EN, CONVERTER_CLOCK_EN, MAIN_OSC_EN, AMP_FULL_SWING, EXECUTE_RELEASE;
   int          miscompares = 0, n_compared = 0, cyc;

   ccs_startup_sequencer #(.WDT_LONG(17'h00010), .WAKE_16K(17'h00008), .WAKE_32K(17'h00008)) i_dut (.*);

   initial forever #20 CLOCK = ~CLOCK;
   initial forever #50 MAIN_OSC_IN = ~MAIN_OSC_IN;
   initial forever #60 WATCHDOG_OSC_IN = ~WATCHDOG_OSC_IN;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge CLOCK);
      PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge CLOCK);
         if (PREADY === 1'b1) break;
      end
      if (n == 20) begin miscompares++; summarize(); end
      rd = PRDATA; er = PSLVERR;
      PSEL <= 0; PENABLE <= 0;
   endtask

   // Counts cycles until execution is released; a hang ends the run.
   task automatic wait_release;
      for (cyc = 0; EXECUTE_RELEASE !== 1'b1; cyc++) begin
         @(posedge CLOCK);
         if (cyc > 20000) begin miscompares++; summarize(); end
      end
   endtask

   task automatic start(input logic [3:0] sel, input logic [1:0] startup_time_select, input logic opt);
      @(posedge CLOCK);
      NRST <= 0; CLOCK_SOURCE_SELECT <= sel; STARTUP_TIME_SELECT <= startup_time_select; AMPLIFIER_OPTION <= opt;
      repeat (10) @(posedge CLOCK);
      NRST <= 1;
      @(posedge CLOCK);
      wait_release();
   endtask

   task automatic t_default;
      start(4'h1, 2'h2, 1'b1);
      chk(cyc >= 48, 1);
      apb(0, 12'h004, 0);
      chk(rd, 32'h00610033);
      chk({CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, PROGRAM_STORE_CLOCK_EN, OSC_RANGE}, 5'h1c);
      apb(1, 12'h000, 32'h10);
      repeat (2) @(posedge CLOCK);
      chk(ASYNC_TIMER_CLOCK_EN, 1);
      apb(1, 12'h000, 32'h11);
      repeat (2) @(posedge CLOCK);
      chk({CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, ASYNC_TIMER_CLOCK_EN, MAIN_OSC_EN}, 4'h7);
      WAKE <= 1;
      wait_release();
      WAKE <= 0;
      apb(1, 12'h000, 32'h17);
      repeat (2) @(posedge CLOCK);
      chk({MAIN_OSC_EN, ASYNC_TIMER_CLOCK_EN, CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN}, 4'h4);
      WAKE <= 1;
      wait_release();
      WAKE <= 0;
      chk(cyc >= 12, 1);
      $display("test default done");
   endtask

   task automatic t_crystal;
      start(4'ha, 2'h2, 1'b0);
      chk(cyc >= 2400, 1);
      chk({OSC_RANGE, AMP_FULL_SWING}, 3'h7);
      apb(1, 12'h000, 32'h10);
      apb(0, 12'h004, 0);
      chk(rd, 32'h002a0203);
      chk(ASYNC_TIMER_CLOCK_EN, 0);
      apb(0, 12'h008, 0);
      chk(er, 1);
      chk(rd, 0);
      apb(1, 12'h000, 32'h23);
      repeat (2) @(posedge CLOCK);
      chk({CONVERTER_CLOCK_EN, CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN}, 3'h4);
      WAKE <= 1;
      wait_release();
      WAKE <= 0;
      apb(1, 12'h000, 32'h05);
      repeat (2) @(posedge CLOCK);
      chk({MAIN_OSC_EN, CORE_CLOCK_EN, PERIPHERAL_CLOCK_EN, CONVERTER_CLOCK_EN}, 4'h0);
      WAKE <= 1;
      wait_release();
      WAKE <= 0;
      chk(cyc >= 2400, 1);
      $display("test crystal done");
   endtask

   initial begin
      t_default();
      t_crystal();
      summarize();
   end
endmodule // tb_top
